// ---- bcd_digit_scan_output.sv ----
// Result latch, end-of-conversion pulse, multiplexed BCD scan and APB registers.
`timescale 1ns/1ns
//Contract
// - With update tied to end-of-conversion, every finished result except the first after reset or a reference restart reaches the scan outputs.
// - A result loads only if an update rising edge came before ramp-down began.
// - One end-of-conversion pulse is issued at the close of each conversion.
// - The end-of-conversion pulse lasts half a converter clock period.
// - Overrange output rests high and goes low while the result exceeds full scale.
// - A digit strobe is high only while its own digit is on the BCD lines.
// - The half-digit strobe asserts right after each end-of-conversion pulse.
// - Remaining strobes follow one at a time toward the bottom digit, then repeat.
// - Two clock periods of blanking separate consecutive digit slots.
// - A full scan takes eighty converter clocks.
// - Second, third and fourth slots each carry one full decimal digit.
// - The first slot carries half digit, polarity, overrange and underrange codes.
// - The block runs from an externally supplied CMOS-level clock instead of an oscillator.
// - First slot: half-digit bit low for one, polarity bit high for positive.
// - First slot: bit zero high when out of range; half bit tells which.
// - Overrange above 1999 counts, underrange below 180 counts.
// - Reference pulled to negative supply restarts the conversion cycle.
module bcd_digit_scan_output (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic result_latch_strobe,
	input wire logic ref_reset_n,
	input wire logic conv_done,
	input wire logic conv_ramp_down,
	input wire logic [bcd_scan_pkg::COUNT_W-1:0] conv_count,
	input wire logic conv_negative,
	output logic end_of_conv,
	output logic over_range_n,
	output logic digit_strobe_first,
	output logic digit_strobe_second,
	output logic digit_strobe_third,
	output logic digit_strobe_fourth,
	output logic bcd_bit_zero,
	output logic bcd_bit_one,
	output logic bcd_bit_two,
	output logic bcd_bit_three,
	output logic cycle_restart,
	output logic irq,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [bcd_scan_pkg::APB_ADDR_W-1:0] paddr,
	input wire logic [bcd_scan_pkg::APB_DATA_W-1:0] pwdata,
	output logic [bcd_scan_pkg::APB_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr
);
	import bcd_scan_pkg::*;
	default clocking assert_clk @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n || !ce);

	logic update_s1, update_s2, update_s3, ref_s1, ref_s2, ref_low;
	logic update_rise, restart, in_ramp, pending, load, soft_update;
	logic [COUNT_W-1:0] shown_count;
	logic shown_neg, shown_over, shown_under_limit, half_digit, over_now, under_now;
	logic [NIBBLE_W*FULL_DIGITS-1:0] digits;
	logic tick_phase, conv_tick;
	scan_state_e scan_state;
	logic [SLOT_CNT_W-1:0] slot_cnt;
	logic [1:0] digit_idx, data_idx;
	logic [DIGIT_NUM-1:0] strobe;
	logic [NIBBLE_W-1:0] head_nibble, next_nibble, nibble;
	logic [EV_W-1:0] int_status, int_en, events, clr_mask;
	logic setup_phase, wr_access, addr_ok;
	logic [APB_DATA_W-1:0] next_rdata;

	// Both pins come from outside the clock domain and are read only after the second stage.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			update_s1 <= 1'b0;
			update_s2 <= 1'b0;
			update_s3 <= 1'b0;
			ref_s1 <= 1'b1;
			ref_s2 <= 1'b1;
		end else if (ce) begin
			update_s1 <= result_latch_strobe;
			update_s2 <= update_s1;
			update_s3 <= update_s2;
			ref_s1 <= ref_reset_n;
			ref_s2 <= ref_s1;
		end
	end

	assign ref_low = !ref_s2;
	assign update_rise = (update_s2 && !update_s3) || soft_update;
	assign restart = conv_done || ref_low;

	// An edge coinciding with the start of ramp-down is too late to qualify.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			in_ramp <= 1'b0;
			pending <= 1'b0;
		end else if (ce) begin
			if (ref_low || conv_done) begin
				in_ramp <= 1'b0;
				pending <= 1'b0;
			end else begin
				if (conv_ramp_down) begin
					in_ramp <= 1'b1;
				end
				if (update_rise && !in_ramp && !conv_ramp_down) begin
					pending <= 1'b1;
				end
			end
		end
	end

	assign load = conv_done && pending && !ref_low;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			shown_count <= COUNT_RST;
			shown_neg <= 1'b0;
			shown_over <= 1'b0;
			shown_under_limit <= 1'b1;
		end else if (ce && load) begin
			shown_count <= conv_count;
			shown_neg <= conv_negative;
			shown_over <= conv_count > OVER_LIMIT;
			shown_under_limit <= conv_count < UNDER_LIMIT;
		end
	end

	result_digit_split u_split (
		.count(shown_count),
		.digits(digits),
		.half_digit(half_digit),
		.over(over_now),
		.under(under_now)
	);

	// The converter clock is sys_clk halved, so one sys_clk cycle is half its period.
	assign conv_tick = tick_phase;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			end_of_conv <= 1'b0;
			over_range_n <= 1'b1;
			cycle_restart <= 1'b0;
		end else if (ce) begin
			end_of_conv <= conv_done && !ref_low;
			over_range_n <= !over_now;
			cycle_restart <= ref_low;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			tick_phase <= 1'b0;
			scan_state <= SCAN_SHOW;
			slot_cnt <= '0;
			digit_idx <= 2'h0;
		end else if (ce) begin
			if (restart) begin
				tick_phase <= 1'b0;
				scan_state <= SCAN_SHOW;
				slot_cnt <= '0;
				digit_idx <= 2'h0;
			end else begin
				tick_phase <= !tick_phase;
				if (conv_tick) begin
					case (scan_state)
						SCAN_SHOW: begin
							if (slot_cnt == SHOW_LAST) begin
								scan_state <= SCAN_BLANK;
								slot_cnt <= '0;
							end else begin
								slot_cnt <= slot_cnt + 5'h01;
							end
						end
						SCAN_BLANK: begin
							if (slot_cnt == BLANK_LAST) begin
								scan_state <= SCAN_SHOW;
								slot_cnt <= '0;
								digit_idx <= digit_idx + 2'h1;
							end else begin
								slot_cnt <= slot_cnt + 5'h01;
							end
						end
						default: begin
							scan_state <= SCAN_SHOW;
							slot_cnt <= '0;
						end
					endcase
				end
			end
		end
	end

	// Strobes are registered so they line up with the registered nibble.
	genvar s;
	generate
		for (s = 0; s < DIGIT_NUM; s++) begin : g_strobe
			always_ff @(posedge sys_clk) begin
				if (!rst_n) begin
					strobe[s] <= 1'b0;
				end else if (ce) begin
					strobe[s] <= !restart && scan_state == SCAN_SHOW
						&& digit_idx == 2'(s);
				end
			end
		end
	endgenerate

	assign {digit_strobe_fourth, digit_strobe_third, digit_strobe_second,
		digit_strobe_first} = strobe;

	// Out of range forces the half-digit bit so the decoder can tell over from under.
	always_comb begin
		head_nibble[3] = shown_over ? 1'b0 : (shown_under_limit ? 1'b1 : !half_digit);
		head_nibble[2] = !shown_neg;
		head_nibble[1] = !half_digit || shown_over || shown_under_limit;
		head_nibble[0] = shown_over || shown_under_limit;
	end

	// During blanking the next digit is already presented so the lines settle early.
	assign data_idx = (scan_state == SCAN_BLANK) ? digit_idx + 2'h1 : digit_idx;

	always_comb begin
		case (data_idx)
			2'h0: next_nibble = head_nibble;
			2'h1: next_nibble = digits[0 +: NIBBLE_W];
			2'h2: next_nibble = digits[NIBBLE_W +: NIBBLE_W];
			2'h3: next_nibble = digits[2*NIBBLE_W +: NIBBLE_W];
			default: next_nibble = head_nibble;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			nibble <= 4'h0;
		end else if (ce) begin
			nibble <= restart ? head_nibble : next_nibble;
		end
	end

	assign {bcd_bit_three, bcd_bit_two, bcd_bit_one, bcd_bit_zero} = nibble;

	assign events[EV_EOC] = conv_done && !ref_low;
	assign events[EV_LOAD] = load;
	assign events[EV_OVER] = load && conv_count > OVER_LIMIT;
	assign events[EV_UNDER] = load && conv_count < UNDER_LIMIT;

	assign setup_phase = psel && !penable;
	assign wr_access = psel && penable && pwrite;
	assign addr_ok = paddr == ADDR_CTRL || paddr == ADDR_RESULT || paddr == ADDR_INT_STATUS
		|| paddr == ADDR_INT_EN || paddr == ADDR_INT_CLR;
	assign clr_mask = (wr_access && paddr == ADDR_INT_CLR) ? pwdata[EV_W-1:0] : '0;
	assign pready = 1'b1;

	// A new event in the clearing cycle stays set.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			int_status <= INT_STATUS_RST;
			irq <= 1'b0;
		end else if (ce) begin
			int_status <= (int_status & ~clr_mask) | events;
			irq <= |(int_status & int_en);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			int_en <= INT_EN_RST;
			soft_update <= 1'b0;
		end else if (ce) begin
			soft_update <= wr_access && paddr == ADDR_CTRL && pwdata[CTRL_UPDATE_BIT];
			if (wr_access && paddr == ADDR_INT_EN) begin
				int_en <= pwdata[EV_W-1:0];
			end
		end
	end

	always_comb begin
		next_rdata = '0;
		case (paddr)
			ADDR_RESULT: begin
				next_rdata[COUNT_W-1:0] = shown_count;
				next_rdata[RES_NEG_BIT] = shown_neg;
				next_rdata[RES_OVER_BIT] = shown_over;
				next_rdata[RES_UNDER_BIT] = shown_under_limit;
			end
			ADDR_INT_STATUS: next_rdata[EV_W-1:0] = int_status;
			ADDR_INT_EN: next_rdata[EV_W-1:0] = int_en;
			default: next_rdata = '0;
		endcase
	end

	// Read data is captured in the setup cycle so the access cycle answers at once.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			prdata <= '0;
			pslverr <= 1'b0;
		end else if (ce && setup_phase) begin
			prdata <= next_rdata;
			pslverr <= !addr_ok;
		end
	end

	property p_eoc_after_done;
		conv_done && !ref_low |=> end_of_conv;
	endproperty
	a_eoc_after_done: assert property (p_eoc_after_done) else $error("no end pulse");
	property p_eoc_width;
		end_of_conv && !conv_done |=> !end_of_conv;
	endproperty
	a_eoc_width: assert property (p_eoc_width) else $error("end pulse too long");
	property p_over_pin;
		load && conv_count > OVER_LIMIT |=> ##1 !over_range_n;
	endproperty
	a_over_pin: assert property (p_over_pin) else $error("overrange pin not low");
	property p_one_strobe;
		disable iff (!rst_n) $onehot0(strobe);
	endproperty
	a_one_strobe: assert property (p_one_strobe) else $error("two strobes high");
	property p_first_after_eoc;
		disable iff (!rst_n || !ce || restart) end_of_conv |=> digit_strobe_first;
	endproperty
	a_first_after_eoc: assert property (p_first_after_eoc) else $error("first strobe late");
	property p_next_strobe;
		disable iff (!rst_n || !ce || restart)
		$fell(digit_strobe_first) && !end_of_conv |-> ##4 $rose(digit_strobe_second);
	endproperty
	a_next_strobe: assert property (p_next_strobe) else $error("second strobe out of order");
	property p_blank_two_clocks;
		disable iff (!rst_n || !ce || restart)
		$fell(|strobe) && !end_of_conv |-> (!(|strobe))[*4] ##1 (|strobe);
	endproperty
	a_blank_two_clocks: assert property (p_blank_two_clocks) else $error("blanking wrong");
	property p_scan_period;
		disable iff (!rst_n || !ce || restart)
		$rose(digit_strobe_first) |-> ##160 $rose(digit_strobe_first);
	endproperty
	a_scan_period: assert property (p_scan_period) else $error("scan period wrong");
	property p_blank_low;
		scan_state == SCAN_BLANK |=> !(|strobe);
	endproperty
	a_blank_low: assert property (p_blank_low) else $error("strobe in blanking");
	property p_polarity;
		digit_strobe_first |-> bcd_bit_two == !shown_neg;
	endproperty
	a_polarity: assert property (p_polarity) else $error("polarity bit wrong");
	property p_over_code;
		digit_strobe_first && shown_over |-> bcd_bit_zero && !bcd_bit_three;
	endproperty
	a_over_code: assert property (p_over_code) else $error("overrange code wrong");
	property p_hold_result;
		!load |=> $stable(shown_count);
	endproperty
	a_hold_result: assert property (p_hold_result) else $error("result changed");
	property p_late_edge;
		in_ramp && !pending && !conv_done |=> !pending;
	endproperty
	a_late_edge: assert property (p_late_edge) else $error("late update accepted");
endmodule // bcd_digit_scan_output

// ---- bcd_scan_pkg.sv ----
// Constants, register map and scan states shared by the BCD digit scan output block.
package bcd_scan_pkg;
	localparam int COUNT_W = 12;
	localparam int NIBBLE_W = 4;
	localparam int DIGIT_NUM = 4;
	localparam int FULL_DIGITS = 3;
	localparam logic [11:0] OVER_LIMIT = 12'h7CF;
	localparam logic [11:0] UNDER_LIMIT = 12'h0B4;
	localparam logic [11:0] HALF_WEIGHT = 12'h3E8;
	localparam logic [11:0] COUNT_RST = 12'h000;
	localparam int MUX_DIVIDE = 80;
	localparam int BLANK_CLKS = 2;
	localparam int SLOT_CLKS = MUX_DIVIDE / DIGIT_NUM;
	localparam int SHOW_CLKS = SLOT_CLKS - BLANK_CLKS;
	localparam int SLOT_CNT_W = 5;
	localparam logic [SLOT_CNT_W-1:0] SHOW_LAST = SLOT_CNT_W'(SHOW_CLKS - 1);
	localparam logic [SLOT_CNT_W-1:0] BLANK_LAST = SLOT_CNT_W'(BLANK_CLKS - 1);
	localparam int APB_ADDR_W = 5;
	localparam int APB_DATA_W = 32;
	localparam logic [APB_ADDR_W-1:0] ADDR_CTRL = 5'h00;
	localparam logic [APB_ADDR_W-1:0] ADDR_RESULT = 5'h04;
	localparam logic [APB_ADDR_W-1:0] ADDR_INT_STATUS = 5'h08;
	localparam logic [APB_ADDR_W-1:0] ADDR_INT_EN = 5'h0C;
	localparam logic [APB_ADDR_W-1:0] ADDR_INT_CLR = 5'h10;
	localparam int CTRL_UPDATE_BIT = 0;
	localparam int RES_NEG_BIT = 12;
	localparam int RES_OVER_BIT = 13;
	localparam int RES_UNDER_BIT = 14;
	localparam int EV_W = 4;
	localparam int EV_EOC = 0;
	localparam int EV_LOAD = 1;
	localparam int EV_OVER = 2;
	localparam int EV_UNDER = 3;
	localparam logic [EV_W-1:0] INT_EN_RST = 4'h0;
	localparam logic [EV_W-1:0] INT_STATUS_RST = 4'h0;
	typedef enum logic [0:0] {
		SCAN_SHOW = 1'b0,
		SCAN_BLANK = 1'b1
	} scan_state_e;
endpackage

// ---- result_digit_split.sv ----
// Splits a latched conversion count into decimal digits and range flags.
`timescale 1ns/1ns
module result_digit_split (
	input wire logic [bcd_scan_pkg::COUNT_W-1:0] count,
	output logic [bcd_scan_pkg::NIBBLE_W*bcd_scan_pkg::FULL_DIGITS-1:0] digits,
	output logic half_digit,
	output logic over,
	output logic under
);
	import bcd_scan_pkg::*;

	function automatic logic [COUNT_W-1:0] pow10(input int n);
		logic [COUNT_W-1:0] p;
		p = 12'h001;
		for (int k = 0; k < n; k++) begin
			p = COUNT_W'(p * 12'h00A);
		end
		return p;
	endfunction

	// Slot 0 of the vector is the hundreds digit, slot 2 the bottom_digit.
	genvar g;
	generate
		for (g = 0; g < FULL_DIGITS; g++) begin : g_digit
			assign digits[g*NIBBLE_W +: NIBBLE_W] =
				NIBBLE_W'((count / pow10(FULL_DIGITS - 1 - g)) % 12'h00A);
		end
	endgenerate

	assign half_digit = count >= HALF_WEIGHT;
	assign over = count > OVER_LIMIT;
	assign under = count < UNDER_LIMIT;
endmodule // result_digit_split

// ---- digit_demux_model.sv ----
// Display demultiplexer model that keeps the last nibble strobed into each digit slot.
`timescale 1ns/1ns
module digit_demux_model (
	input wire logic sys_clk,
	input wire logic [3:0] strobes,
	input wire logic [3:0] nibble,
	output logic [15:0] shown,
	output int scans,
	output logic overlap
);
	logic last_fourth;
	initial begin
		shown = 16'h0000;
		scans = 0;
		overlap = 1'b0;
		last_fourth = 1'b0;
	end
	// A decoder latches only while its strobe is high, so blanking-time values are never kept.
	always @(posedge sys_clk) begin
		for (int i = 0; i < 4; i++) begin
			if (strobes[i] === 1'b1) begin
				shown[15-4*i -: 4] <= nibble;
			end
		end
		if ($countones(strobes) > 1) begin
			overlap <= 1'b1;
		end
		if (last_fourth && strobes[3] !== 1'b1) begin
			scans <= scans + 1;
		end
		last_fourth <= (strobes[3] === 1'b1);
	end
endmodule // digit_demux_model

// ---- bcd_digit_scan_output_tb.sv ----
// Self-checking bench for the BCD digit scan output block.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin \
	num_checks++; \
	if ((g) !== (e)) begin \
		n_fail++; \
		$display("unexpected %s exp %0h got %0h", nm, e, g); \
	end \
end
module bcd_digit_scan_output_tb;
	import bcd_scan_pkg::*;
	logic sys_clk, rst_n, ce, result_latch_strobe, ref_reset_n, conv_done, conv_ramp_down;
	logic [COUNT_W-1:0] conv_count;
	logic conv_negative, end_of_conv, over_range_n, cycle_restart, irq;
	logic digit_strobe_first, digit_strobe_second, digit_strobe_third, digit_strobe_fourth;
	logic bcd_bit_zero, bcd_bit_one, bcd_bit_two, bcd_bit_three;
	logic psel, penable, pwrite, pready, pslverr;
	logic [APB_ADDR_W-1:0] paddr;
	logic [APB_DATA_W-1:0] pwdata, prdata, rd;
	logic er, overlap;
	logic [3:0] strobes, nibble;
	logic [15:0] shown;
	int scans, n_fail, num_checks;
	int cs[5] = '{2000, 1999, 180, 179, 2999};
	logic [4:0] ng = 5'b10101;
	assign strobes = {digit_strobe_fourth, digit_strobe_third, digit_strobe_second,
		digit_strobe_first};
	assign nibble = {bcd_bit_three, bcd_bit_two, bcd_bit_one, bcd_bit_zero};
	bcd_digit_scan_output bcd_digit_scan_output_inst (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
		.result_latch_strobe(result_latch_strobe), .ref_reset_n(ref_reset_n),
		.conv_done(conv_done), .conv_ramp_down(conv_ramp_down), .conv_count(conv_count),
		.conv_negative(conv_negative), .end_of_conv(end_of_conv), .over_range_n(over_range_n),
		.digit_strobe_first(digit_strobe_first), .digit_strobe_second(digit_strobe_second),
		.digit_strobe_third(digit_strobe_third), .digit_strobe_fourth(digit_strobe_fourth),
		.bcd_bit_zero(bcd_bit_zero), .bcd_bit_one(bcd_bit_one), .bcd_bit_two(bcd_bit_two),
		.bcd_bit_three(bcd_bit_three), .cycle_restart(cycle_restart), .irq(irq),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	digit_demux_model digit_demux_model_inst (.sys_clk(sys_clk), .strobes(strobes),
		.nibble(nibble), .shown(shown), .scans(scans), .overlap(overlap));
	always #20 sys_clk = ~sys_clk;
	function automatic logic [15:0] exp_show(input int c, input logic neg);
		logic ov, un, hf;
		int r;
		ov = (c > 1999);
		un = (c < 180);
		hf = (c >= 1000);
		r = c % 1000;
		return {ov ? 1'b0 : (un ? 1'b1 : !hf), !neg, !hf | ov | un, ov | un,
			4'(r / 100), 4'(r / 10 % 10), 4'(r % 10)};
	endfunction
	task automatic complete_run();
		if (n_fail == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Zero wait states are not assumed; the access phase lasts until pready is seen high.
	task automatic apb(input logic wr, input logic [APB_ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic pin_pulse();
		result_latch_strobe <= 1'b1;
		repeat (4) @(posedge sys_clk);
		result_latch_strobe <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask
	// Mode 1 pin edge before ramp-down, 2 register update, 3 pin edge during ramp-down.
	task automatic convert(input int c, input logic neg, input int mode);
		if (mode == 2) apb(1'b1, ADDR_CTRL, 32'h1);
		@(posedge sys_clk);
		if (mode == 1) pin_pulse();
		conv_ramp_down <= 1'b1;
		@(posedge sys_clk);
		conv_ramp_down <= 1'b0;
		if (mode == 3) pin_pulse();
		repeat (3) @(posedge sys_clk);
		conv_count <= 12'(c);
		conv_negative <= neg;
		conv_done <= 1'b1;
		@(posedge sys_clk);
		conv_done <= 1'b0;
		#1;
		`CHK("eoc", 1'b1, end_of_conv)
		@(posedge sys_clk);
		#1;
		`CHK("eoc width", 1'b0, end_of_conv)
		`CHK("first strobe", 4'h1, strobes)
	endtask
	task automatic scan_timing();
		int n;
		for (int i = 0; i < 4; i++) begin
			n = 0;
			while (strobes === 4'(1 << i) && n < 200) begin
				@(posedge sys_clk);
				#1;
				n++;
			end
			`CHK("slot cycles", 36, n)
			n = 0;
			while (strobes === 4'h0 && n < 200) begin
				@(posedge sys_clk);
				#1;
				n++;
			end
			`CHK("blank cycles", 4, n)
		end
		`CHK("wrap", 4'h1, strobes)
	endtask
	task automatic check_show(input int c, input logic neg);
		int s;
		s = scans;
		for (int n = 0; n < 400 && scans == s; n++) @(posedge sys_clk);
		#1;
		`CHK("scan seen", 1'b1, scans != s)
		`CHK("digits", exp_show(c, neg), shown)
		`CHK("over pin", logic'(c <= 1999), over_range_n)
		apb(1'b0, ADDR_RESULT, 32'h0);
		`CHK("result", {17'h0, logic'(c < 180), logic'(c > 1999), neg, 12'(c)}, rd)
	endtask
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_fail++;
		complete_run();
	end
	initial begin
		{sys_clk, rst_n, result_latch_strobe, conv_done, conv_ramp_down, conv_negative} = '0;
		{psel, penable, pwrite, paddr, pwdata, conv_count} = '0;
		ce = 1'b1;
		ref_reset_n = 1'b1;
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		#1;
		`CHK("reset strobes", 4'h0, strobes)
		`CHK("reset over", 1'b1, over_range_n)
		`CHK("reset irq", 1'b0, irq)
		apb(1'b0, ADDR_RESULT, 32'h0);
		`CHK("reset result", 32'h4000, rd)
		apb(1'b0, 5'h14, 32'h0);
		`CHK("unmapped err", 1'b1, er)
		apb(1'b1, ADDR_INT_EN, 32'h3);
		convert(1234, 1'b0, 1);
		scan_timing();
		check_show(1234, 1'b0);
		`CHK("irq on", 1'b1, irq)
		apb(1'b0, ADDR_INT_STATUS, 32'h0);
		`CHK("status", 32'h3, rd)
		apb(1'b1, ADDR_INT_CLR, 32'hF);
		apb(1'b0, ADDR_INT_STATUS, 32'h0);
		`CHK("cleared", 32'h0, rd)
		`CHK("irq off", 1'b0, irq)
		convert(567, 1'b1, 3);
		check_show(1234, 1'b0);
		apb(1'b0, ADDR_INT_STATUS, 32'h0);
		`CHK("no load", 32'h1, rd)
		apb(1'b1, ADDR_INT_EN, 32'h0);
		apb(1'b1, ADDR_INT_CLR, 32'hF);
		for (int i = 0; i < 5; i++) begin
			convert(cs[i], ng[i], 1 + i % 2);
			check_show(cs[i], ng[i]);
		end
		apb(1'b0, ADDR_INT_STATUS, 32'h0);
		`CHK("all events", 32'hF, rd)
		`CHK("irq masked", 1'b0, irq)
		ref_reset_n <= 1'b0;
		repeat (5) @(posedge sys_clk);
		#1;
		`CHK("restart", 1'b1, cycle_restart)
		`CHK("restart strobes", 4'h0, strobes)
		apb(1'b1, ADDR_CTRL, 32'h1);
		conv_count <= 12'd42;
		conv_done <= 1'b1;
		@(posedge sys_clk);
		conv_done <= 1'b0;
		ref_reset_n <= 1'b1;
		repeat (5) @(posedge sys_clk);
		#1;
		`CHK("restart off", 1'b0, cycle_restart)
		check_show(2999, 1'b1);
		// Clock enable low must hold the strobes and BCD lines still across at least one slot boundary.
		@(posedge sys_clk);
		ce <= 1'b0;
		@(posedge sys_clk);
		#1;
		rd = {24'h0, strobes, nibble};
		repeat (50) @(posedge sys_clk);
		#1;
		`CHK("frozen", rd, {24'h0, strobes, nibble})
		@(posedge sys_clk);
		ce <= 1'b1;
		check_show(2999, 1'b1);
		`CHK("overlap", 1'b0, overlap)
		complete_run();
	end
endmodule // bcd_digit_scan_output_tb
